// ---- verilog/fcsm_pkg.sv ----
// Constants, types and register map of the parallel flash host controller
// What this block does
// - Drive high-voltage query with pin select bits
// - Query entry: two unlocks plus query command
// - Reset command leaves query mode
// - Write needs select and write low, output high
// - Timeout flag high means host writes reset
// - Program is four write cycles
package fcsm_pkg;
    localparam int AW = 19;
    localparam int DW = 16;
    localparam int CW = 8;
    localparam int CLK_PERIOD_PS = 8000;

    // Bus timing; least times, so cycle counts round up
    localparam int T_ADDR_SETUP_NS = 10;
    localparam int T_WE_PULSE_NS = 35;
    localparam int T_READ_ACC_NS = 70;
    localparam int T_RST_PULSE_NS = 500;
    localparam int T_RST_REC_NS = 50;
    localparam logic [CW-1:0] SETUP_CYC =
        CW'((T_ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CW-1:0] WP_CYC =
        CW'((T_WE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CW-1:0] ACC_CYC =
        CW'((T_READ_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CW-1:0] RP_CYC =
        CW'((T_RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CW-1:0] RH_CYC =
        CW'((T_RST_REC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // Command defaults
    localparam logic [AW-1:0] UNLOCK1_ADDR = 19'h00555;
    localparam logic [DW-1:0] UNLOCK1_DATA = 16'h00aa;
    localparam logic [AW-1:0] UNLOCK2_ADDR = 19'h002aa;
    localparam logic [DW-1:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [DW-1:0] CMD_PROGRAM = 16'h00a0;
    localparam logic [DW-1:0] CMD_QUERY = 16'h0090;
    localparam logic [DW-1:0] CMD_RESET = 16'h00f0;
    localparam logic [CW-1:0] POLL_MAX = 8'hff;

    // Register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RESULT = 8'h14;

    // Field positions
    localparam int CFG_BYTE = 0;
    localparam int CFG_HV_A9 = 1;
    localparam int CFG_HV_RST = 2;
    localparam int STS_BUSY = 0;
    localparam int STS_ERR = 1;
    localparam int STS_QUERY = 2;
    localparam int STS_RDY = 3;
    localparam int POLL_BIT = 7;
    localparam int FAIL_BIT = 5;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_READ = 3'h1,
        OP_PROG = 3'h2,
        OP_QUERY = 3'h3,
        OP_EXIT = 3'h4,
        OP_HWRST = 3'h5
    } fcsm_op_e;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic restart_n;
        logic byte_n;
        logic id_voltage_address_pin;
        logic restart_hv;
        logic dq_oe_n;
        logic [AW-1:0] addr;
        logic [DW-1:0] dq_out;
    } fcsm_pins_s;
endpackage : fcsm_pkg

// ---- verilog/fcsm_host.sv ----
// Host-side command sequencer for an asynchronous parallel NOR flash
//
// Local design decisions: the plain strobed port and the placing of the registers.
module fcsm_host #(
    parameter logic [fcsm_pkg::AW-1:0] UNLOCK1_ADDR = fcsm_pkg::UNLOCK1_ADDR,
    parameter logic [fcsm_pkg::DW-1:0] UNLOCK1_DATA = fcsm_pkg::UNLOCK1_DATA,
    parameter logic [fcsm_pkg::AW-1:0] UNLOCK2_ADDR = fcsm_pkg::UNLOCK2_ADDR,
    parameter logic [fcsm_pkg::DW-1:0] UNLOCK2_DATA = fcsm_pkg::UNLOCK2_DATA,
    parameter logic [fcsm_pkg::DW-1:0] CMD_PROGRAM = fcsm_pkg::CMD_PROGRAM,
    parameter logic [fcsm_pkg::DW-1:0] CMD_QUERY = fcsm_pkg::CMD_QUERY,
    parameter logic [fcsm_pkg::DW-1:0] CMD_RESET = fcsm_pkg::CMD_RESET,
    parameter logic [fcsm_pkg::CW-1:0] POLL_MAX = fcsm_pkg::POLL_MAX
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Software register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Flash pins
    output fcsm_pkg::fcsm_pins_s fl_pins,
    input wire logic [fcsm_pkg::DW-1:0] dq_in,
    input wire logic ready_busy_output
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_WLOW = 3'b010,
        ST_WREC = 3'b011,
        ST_RLOW = 3'b100,
        ST_NEXT = 3'b101,
        ST_HWRST = 3'b110,
        ST_HWREC = 3'b111
    } fcsm_st_e;

    logic [1:0] rs_q;
    logic rst_n;
    fcsm_st_e st_q, st_d;
    fcsm_pkg::fcsm_op_e op_q, op_d;
    fcsm_pkg::fcsm_pins_s pins_q, pins_d;
    logic [2:0] step_q, step_d;
    logic [fcsm_pkg::CW-1:0] cnt_q, cnt_d, poll_q, poll_d;
    logic is_wr_q, is_wr_d, fail_seen_q, fail_seen_d;
    logic [2:0] cfg_q, cfg_d;
    logic [fcsm_pkg::AW-1:0] addr_q, addr_d;
    logic [fcsm_pkg::DW-1:0] data_q, data_d, result_q, result_d;
    logic err_q, err_d, query_q, query_d;
    logic [31:0] rdata_q, rdata_d;
    logic [2:0] wcnt_q, wcnt_d;

    // Reset is released through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rs_q <= 2'h0;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_n = rs_q[1];

    assign reg_rdata = rdata_q;
    assign fl_pins = pins_q;

    always_comb begin
        logic start;
        logic set_err;
        logic bus_go;
        logic bus_wr;
        logic [fcsm_pkg::AW-1:0] bus_a;
        logic [fcsm_pkg::DW-1:0] bus_dat;
        logic done;
        start = 1'b0;
        set_err = 1'b0;
        bus_go = 1'b0;
        bus_wr = 1'b0;
        bus_a = addr_q;
        bus_dat = data_q;
        done = 1'b0;
        st_d = st_q;
        op_d = op_q;
        pins_d = pins_q;
        step_d = step_q;
        cnt_d = cnt_q;
        poll_d = poll_q;
        is_wr_d = is_wr_q;
        fail_seen_d = fail_seen_q;
        cfg_d = cfg_q;
        addr_d = addr_q;
        data_d = data_q;
        result_d = result_q;
        query_d = query_q;
        wcnt_d = wcnt_q;
        rdata_d = 32'h0;

        // Register writes; configuration is steady while busy
        if (reg_wr && st_q == ST_IDLE) begin
            unique case (reg_addr)
                fcsm_pkg::REG_CTRL: start = 1'b1;
                fcsm_pkg::REG_CFG: cfg_d = reg_wdata[2:0];
                fcsm_pkg::REG_ADDR: addr_d = reg_wdata[fcsm_pkg::AW-1:0];
                fcsm_pkg::REG_DATA: data_d = reg_wdata[fcsm_pkg::DW-1:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                fcsm_pkg::REG_CFG: rdata_d = {29'h0, cfg_q};
                fcsm_pkg::REG_ADDR: rdata_d = {13'h0, addr_q};
                fcsm_pkg::REG_DATA: rdata_d = {16'h0, data_q};
                fcsm_pkg::REG_STATUS: rdata_d = {28'h0, ready_busy_output,
                    query_q, err_q, st_q != ST_IDLE};
                fcsm_pkg::REG_RESULT: rdata_d = {16'h0, result_q};
                default: rdata_d = 32'h0;
            endcase
        end

        // Static pins follow configuration
        pins_d.byte_n = !cfg_q[fcsm_pkg::CFG_BYTE];
        pins_d.id_voltage_address_pin = cfg_q[fcsm_pkg::CFG_HV_A9];
        pins_d.restart_hv = cfg_q[fcsm_pkg::CFG_HV_RST];

        unique case (st_q)
            ST_IDLE: begin
                if (start) begin
                    op_d = fcsm_pkg::fcsm_op_e'(reg_wdata[2:0]);
                    step_d = 3'h0;
                    poll_d = '0;
                    fail_seen_d = 1'b0;
                    wcnt_d = 3'h0;
                    if (op_d == fcsm_pkg::OP_HWRST) begin
                        pins_d.restart_n = 1'b0;
                        cnt_d = fcsm_pkg::RP_CYC;
                        st_d = ST_HWRST;
                    end else if (op_d != fcsm_pkg::OP_NONE) begin
                        st_d = ST_NEXT;
                    end
                end
            end
            ST_NEXT: begin
                unique case (op_q)
                    fcsm_pkg::OP_READ: begin
                        // Query-mode code and protection reads are plain reads
                        if (step_q == 3'h0) begin
                            bus_go = 1'b1;
                        end else begin
                            done = 1'b1;
                        end
                    end
                    fcsm_pkg::OP_PROG: begin
                        unique case (step_q)
                            3'h0: begin
                                bus_go = 1'b1;
                                bus_wr = 1'b1;
                                bus_a = UNLOCK1_ADDR;
                                bus_dat = UNLOCK1_DATA;
                            end
                            3'h1: begin
                                bus_go = 1'b1;
                                bus_wr = 1'b1;
                                bus_a = UNLOCK2_ADDR;
                                bus_dat = UNLOCK2_DATA;
                            end
                            3'h2: begin
                                bus_go = 1'b1;
                                bus_wr = 1'b1;
                                bus_a = UNLOCK1_ADDR;
                                bus_dat = CMD_PROGRAM;
                            end
                            3'h3: begin
                                // Any address order is fine
                                bus_go = 1'b1;
                                bus_wr = 1'b1;
                            end
                            3'h4: bus_go = 1'b1;
                            3'h5: begin
                                // Compare polling bit with the true data
                                if (result_q[fcsm_pkg::POLL_BIT]
                                        == data_q[fcsm_pkg::POLL_BIT]) begin
                                    done = 1'b1;
                                end else if (fail_seen_q
                                        || poll_q == POLL_MAX) begin
                                    // Bit stuck at zero also lands here
                                    set_err = 1'b1;
                                    bus_go = 1'b1;
                                    bus_wr = 1'b1;
                                    bus_a = UNLOCK1_ADDR;
                                    bus_dat = CMD_RESET;
                                    step_d = 3'h6;
                                end else begin
                                    fail_seen_d =
                                        result_q[fcsm_pkg::FAIL_BIT];
                                    poll_d = poll_q + 1'b1;
                                    bus_go = 1'b1;
                                    step_d = 3'h4;
                                end
                            end
                            default: done = 1'b1;
                        endcase
                    end
                    fcsm_pkg::OP_QUERY: begin
                        bus_go = step_q != 3'h3;
                        bus_wr = 1'b1;
                        bus_a = step_q == 3'h1 ? UNLOCK2_ADDR : UNLOCK1_ADDR;
                        bus_dat = step_q == 3'h0 ? UNLOCK1_DATA
                            : step_q == 3'h1 ? UNLOCK2_DATA : CMD_QUERY;
                        if (step_q == 3'h3) begin
                            query_d = 1'b1;
                            done = 1'b1;
                        end
                    end
                    fcsm_pkg::OP_EXIT: begin
                        // One cycle, any address
                        bus_go = step_q == 3'h0;
                        bus_wr = 1'b1;
                        bus_a = UNLOCK1_ADDR;
                        bus_dat = CMD_RESET;
                        if (step_q != 3'h0) begin
                            query_d = 1'b0;
                            done = 1'b1;
                        end
                    end
                    default: done = 1'b1;
                endcase
                if (bus_go) begin
                    // Command cycles are always whole and in order
                    pins_d.ce_n = 1'b0;
                    pins_d.addr = bus_a;
                    pins_d.dq_out = cfg_q[fcsm_pkg::CFG_BYTE]
                        ? {8'h0, bus_dat[7:0]} : bus_dat;
                    pins_d.dq_oe_n = !bus_wr;
                    is_wr_d = bus_wr;
                    cnt_d = fcsm_pkg::SETUP_CYC;
                    st_d = ST_SETUP;
                end
                if (done) begin
                    st_d = ST_IDLE;
                end
            end
            ST_SETUP: begin
                if (cnt_q == '0) begin
                    if (is_wr_q) begin
                        pins_d.we_n = 1'b0;
                        cnt_d = fcsm_pkg::WP_CYC;
                        st_d = ST_WLOW;
                    end else begin
                        pins_d.oe_n = 1'b0;
                        cnt_d = fcsm_pkg::ACC_CYC;
                        st_d = ST_RLOW;
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_WLOW: begin
                if (cnt_q == '0) begin
                    // Data still driven across the rising edge
                    pins_d.we_n = 1'b1;
                    wcnt_d = wcnt_q + 1'b1;
                    st_d = ST_WREC;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_WREC: begin
                pins_d.ce_n = 1'b1;
                pins_d.dq_oe_n = 1'b1;
                step_d = step_q + 1'b1;
                if (op_q == fcsm_pkg::OP_PROG && step_q == 3'h6) begin
                    step_d = 3'h7;
                end
                st_d = ST_NEXT;
            end
            ST_RLOW: begin
                if (cnt_q == '0) begin
                    result_d = dq_in;
                    pins_d.oe_n = 1'b1;
                    pins_d.ce_n = 1'b1;
                    step_d = step_q + 1'b1;
                    st_d = ST_NEXT;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_HWRST: begin
                if (cnt_q == '0) begin
                    pins_d.restart_n = 1'b1;
                    cnt_d = fcsm_pkg::RH_CYC;
                    st_d = ST_HWREC;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_HWREC: begin
                query_d = 1'b0;
                if (cnt_q == '0) begin
                    st_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase

        // Set wins over a software clear in the same cycle
        err_d = set_err || (err_q && !(reg_wr && st_q == ST_IDLE
            && reg_addr == fcsm_pkg::REG_STATUS
            && reg_wdata[fcsm_pkg::STS_ERR]));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            op_q <= fcsm_pkg::OP_NONE;
            // Strobes parked high so no command is taken
            pins_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, restart_n: 1'b1,
                byte_n: 1'b1, id_voltage_address_pin: 1'b0,
                restart_hv: 1'b0, dq_oe_n: 1'b1, addr: '0, dq_out: '0};
            step_q <= 3'h0;
            cnt_q <= '0;
            poll_q <= '0;
            is_wr_q <= 1'b0;
            fail_seen_q <= 1'b0;
            cfg_q <= 3'h0;
            addr_q <= '0;
            data_q <= '0;
            result_q <= '0;
            err_q <= 1'b0;
            query_q <= 1'b0;
            wcnt_q <= 3'h0;
            rdata_q <= 32'h0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            pins_q <= pins_d;
            step_q <= step_d;
            cnt_q <= cnt_d;
            poll_q <= poll_d;
            is_wr_q <= is_wr_d;
            fail_seen_q <= fail_seen_d;
            cfg_q <= cfg_d;
            addr_q <= addr_d;
            data_q <= data_d;
            result_q <= result_d;
            err_q <= err_d;
            query_q <= query_d;
            wcnt_q <= wcnt_d;
            rdata_q <= rdata_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_write_strobes: assert property (
        !pins_q.we_n |-> !pins_q.ce_n && pins_q.oe_n && !pins_q.dq_oe_n)
        else $error("write strobe low without select or with output on");
    chk_write_stable: assert property (
        !pins_q.we_n ##1 pins_q.we_n |->
        $stable(pins_q.addr) && $stable(pins_q.dq_out) && !pins_q.dq_oe_n)
        else $error("address or data moved at write strobe rise");
    chk_read_release: assert property (
        !pins_q.oe_n |-> pins_q.dq_oe_n && pins_q.we_n)
        else $error("data driven during a read");
    chk_prog_cycles: assert property (
        st_q == ST_NEXT && op_q == fcsm_pkg::OP_PROG && step_q == 3'h4
        |-> wcnt_q == 3'h4)
        else $error("program did not take four write cycles");
    chk_query_enter: assert property (
        st_q == ST_NEXT && op_q == fcsm_pkg::OP_QUERY && step_q == 3'h3
        |=> query_q && st_q == ST_IDLE && wcnt_q == 3'h3)
        else $error("query mode not entered after three writes");
    chk_query_exit: assert property (
        st_q == ST_NEXT && op_q == fcsm_pkg::OP_EXIT && step_q == 3'h1
        |=> !query_q && wcnt_q == 3'h1)
        else $error("query mode not left after reset command");
    chk_hw_reset: assert property (
        $fell(pins_q.restart_n) |-> (!pins_q.restart_n && pins_q.we_n
        && pins_q.oe_n)[*8])
        else $error("restart pulse too short or bus active");
    chk_power_up: assert property (
        $rose(rst_n) |-> pins_q.we_n && pins_q.ce_n && pins_q.oe_n)
        else $error("strobes not parked after reset");
    chk_fail_reset: assert property (
        st_q == ST_WREC && op_q == fcsm_pkg::OP_PROG && step_q == 3'h6
        |-> err_q && $past(pins_q.dq_out) == CMD_RESET)
        else $error("failed program not followed by reset command");
    chk_width_pin: assert property (
        $changed(cfg_q[fcsm_pkg::CFG_BYTE]) |=>
        pins_q.byte_n == !$past(cfg_q[fcsm_pkg::CFG_BYTE]))
        else $error("width select pin does not follow config");
endmodule : fcsm_host

// ---- sim/fcsm_flash_model.sv ----
// Behavioural model of the parallel NOR flash behind the host sequencer
module fcsm_flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h0000,
    parameter logic [15:0] PART_CODE = 16'h0000,
    parameter logic [3:0] PROT_SECTOR = 4'h3
) (
    // Timing reference
    input wire logic clk,
    // Flash pins
    input fcsm_pkg::fcsm_pins_s pins,
    output logic [15:0] dq,
    output logic rdy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [int];
    logic [15:0] pd = 16'h0000;
    logic [18:0] la = 19'h00000;
    logic tog = 1'h0;
    logic query = 1'h0; // Power-up lands in array reads
    logic fail = 1'h0;
    int st = 0;
    int busy = 0;
    int pwr = 0;
    initial dq = 16'h0000;
    function automatic logic [15:0] cur(input logic [18:0] a);
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction : cur
    function automatic logic [15:0] qcode(input logic [18:0] a);
        case (a[1:0])
            2'h0: return MAKER_CODE;
            2'h1: return PART_CODE;
            2'h2: return {15'h0000, a[18:15] == PROT_SECTOR};
            default: return 16'h0000;
        endcase
    endfunction : qcode
    assign rdy = (busy == 0);
    always @(negedge pins.we_n) la = pins.addr;
    always @(negedge pins.oe_n) tog = ~tog;
    always @(posedge pins.we_n) begin
        // Commands are ignored while programming
        // Writes ignored until the supply settles
        // A failed program still takes the reset command
        if (!pins.ce_n && pins.oe_n && pins.restart_n && pwr == 4
            && (busy == 0 || (fail
            && pins.dq_out == fcsm_pkg::CMD_RESET))) begin
            if (st == 3) begin
                // Protected unless restart pin at high voltage
                if (la[18:15] != PROT_SECTOR || pins.restart_hv) begin
                    // Raising a zero bit halts with the timeout flag
                    fail = |(~cur(la) & pins.dq_out);
                    mem[la] = cur(la) & pins.dq_out;
                end
                pd = pins.dq_out;
                busy = 40;
                st = 0;
            end else if (pins.dq_out == fcsm_pkg::CMD_RESET) begin
                st = 0;
                busy = 0;
                fail = 1'h0;
                query = 1'h0;
            end else if (st == 0 && la == fcsm_pkg::UNLOCK1_ADDR
                && pins.dq_out == fcsm_pkg::UNLOCK1_DATA) st = 1;
            else if (st == 1 && la == fcsm_pkg::UNLOCK2_ADDR
                && pins.dq_out == fcsm_pkg::UNLOCK2_DATA) st = 2;
            else if (st == 2 && pins.dq_out == fcsm_pkg::CMD_PROGRAM) st = 3;
            else if (st == 2 && pins.dq_out == fcsm_pkg::CMD_QUERY) begin
                query = 1'h1;
                st = 0;
            end else st = 0;
        end
    end
    always @(posedge clk) begin
        if (pwr < 4) pwr = pwr + 1;
        if (!pins.restart_n) begin
            busy = 0;
            fail = 1'h0;
            st = 0;
            query = 1'h0;
        end else if (busy > 0 && !fail) busy = busy - 1;
    end
    // Released bus shows a changing pattern, never the last value
    always @(negedge clk) begin
        if (pins.ce_n || pins.oe_n || !pins.restart_n) dq <= ~dq;
        else if (busy != 0) dq <= {8'h00, ~pd[7], tog, fail, 5'h00};
        else if ((query || pins.id_voltage_address_pin) && !pins.addr[6])
            dq <= qcode(pins.addr);
        // Erase is not modelled, so no sector is ever suspended
        else dq <= cur(pins.addr);
    end
endmodule : fcsm_flash_model

// ---- sim/fcsm_host_test.sv ----
// Self-checking bench for the flash host sequencer
module fcsm_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MAKER = 16'h00c3; // Arbitrary value
    localparam logic [15:0] PART = 16'h0a7e; // Arbitrary value
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] v;
    logic [15:0] dq_in;
    logic ready_busy_output;
    logic [18:0] a;
    fcsm_pkg::fcsm_pins_s fl_pins;
    int mismatches = 0;
    int samples_checked = 0;
    int ref_mem [int];
    fcsm_host dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fl_pins(fl_pins), .dq_in(dq_in),
        .ready_busy_output(ready_busy_output));
    fcsm_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_u (
        .clk(clk), .pins(fl_pins), .dq(dq_in), .rdy(ready_busy_output));
    initial forever #4 clk = ~clk;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= ad;
        reg_wdata <= wd;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, output logic [31:0] rv);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 rv = reg_rdata;
    endtask : rd
    task automatic idle();
        int n;
        n = 0;
        do begin
            rd(fcsm_pkg::REG_STATUS, v);
            n++;
        end while (v[0] !== 1'h0 && n < 3000);
        chk(32'(v[0]), 32'h0);
    endtask : idle
    task automatic op(input logic [2:0] code);
        wr(fcsm_pkg::REG_CTRL, {29'h0, code});
        idle();
    endtask : op
    function automatic logic [15:0] peek(input logic [18:0] pa);
        return ref_mem.exists(pa) ? 16'(ref_mem[pa]) : 16'hffff;
    endfunction : peek
    task automatic prog(input logic [18:0] pa, input logic [15:0] pd, input bit ok);
        bit bad;
        // Raising a zero bit makes the flash flag a timeout
        bad = ok && (|(~peek(pa) & pd));
        wr(fcsm_pkg::REG_ADDR, {13'h0, pa});
        wr(fcsm_pkg::REG_DATA, {16'h0, pd});
        op(3'h2);
        rd(fcsm_pkg::REG_STATUS, v);
        chk(v & 32'h2, bad ? 32'h2 : 32'h0);
        wr(fcsm_pkg::REG_STATUS, 32'h2);
        if (ok) ref_mem[pa] = int'(peek(pa) & pd);
    endtask : prog
    task automatic rdchk(input logic [18:0] pa, input logic [15:0] e);
        wr(fcsm_pkg::REG_ADDR, {13'h0, pa});
        op(3'h1);
        rd(fcsm_pkg::REG_RESULT, v);
        chk(v, {16'h0, e});
    endtask : rdchk
    initial begin
        #400000;
        mismatches++;
        end_of_test();
    end
    initial begin
        void'($urandom(23407));
        repeat (5) @(posedge clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk);
        rd(fcsm_pkg::REG_STATUS, v);
        chk(v, 32'h8);
        rd(8'h18, v);
        chk(v, 32'h0);
        $display("test reset done");
        // Scattered words, then a rewrite that tries to raise bits
        for (int i = 0; i < 4; i++) begin
            a = 19'($urandom_range(0, 32'h17fff));
            prog(a, 16'($urandom), 1'h1);
            rdchk(a, peek(a));
            prog(a, 16'($urandom) & 16'hff7f, 1'h1);
            rdchk(a, peek(a));
        end
        $display("test program done");
        op(3'h3);
        rd(fcsm_pkg::REG_STATUS, v);
        chk(v & 32'h4, 32'h4);
        rdchk(19'h00000, MAKER);
        rdchk(19'h00001, PART);
        rdchk(19'h18002, 16'h0001);
        rdchk(19'h08002, 16'h0000);
        rdchk(19'h00000, MAKER);
        op(3'h4);
        rd(fcsm_pkg::REG_STATUS, v);
        chk(v & 32'h4, 32'h0);
        rdchk(a, peek(a));
        $display("test query done");
        prog(19'h18010, 16'h12b4, 1'h0);
        rdchk(19'h18010, peek(19'h18010));
        wr(fcsm_pkg::REG_CFG, 32'h4);
        prog(19'h18010, 16'h12b4, 1'h1);
        wr(fcsm_pkg::REG_CFG, 32'h0);
        rdchk(19'h18010, peek(19'h18010));
        wr(fcsm_pkg::REG_CFG, 32'h2);
        rdchk(19'h00001, PART);
        wr(fcsm_pkg::REG_CFG, 32'h1);
        op(3'h3);
        rd(fcsm_pkg::REG_STATUS, v);
        chk(v & 32'h4, 32'h4);
        chk(32'(fl_pins.byte_n), 32'h0);
        op(3'h4);
        wr(fcsm_pkg::REG_CFG, 32'h0);
        $display("test protection done");
        op(3'h3);
        op(3'h5);
        rd(fcsm_pkg::REG_STATUS, v);
        chk(v & 32'h4, 32'h0);
        rdchk(a, peek(a));
        // A register write while busy must be dropped
        wr(fcsm_pkg::REG_CTRL, 32'h1);
        wr(fcsm_pkg::REG_ADDR, 32'h0);
        idle();
        rd(fcsm_pkg::REG_ADDR, v);
        chk(v, {13'h0, a});
        $display("test restart done");
        end_of_test();
    end
endmodule : fcsm_host_test
